// ---- hw/adc_osr_clkmux_regs.sv ----
// APB register bank for record-path oversampling, DSP core count and
// decimation, and the clock-output divider source select.
// Assumes an APB master in the CLK domain; registers are 8 bits in 32-bit words.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/10ps
module adc_osr_clkmux_regs (
    input wire logic CLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [osr_regs_pkg::APB_AW-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic [osr_regs_pkg::OSR_W:0] OSR_RATIO,
    output logic [osr_regs_pkg::CNT_W:0] INSTR_COUNT,
    output logic [osr_regs_pkg::REC_DSP_DECIMATION_W:0] REC_DSP_DECIMATION_FACTOR,
    output logic DSP_ACTIVE,
    output osr_regs_pkg::clkout_divider_input_t CLKOUT_SRC
);
    import osr_regs_pkg::*;

    typedef struct packed {
        logic ready;
        logic slverr;
        logic [31:0] rdata;
        logic [OSR_W-1:0] osr;
        logic [CNT_HI_W-1:0] hi_pend;
        logic [CNT_HI_W-1:0] hi_live;
        logic hi_waiting;
        logic [CNT_LO_W-1:0] lo;
        logic [REC_DSP_DECIMATION_W-1:0] rec_dsp_decimation;
        logic [CLKSRC_W-1:0] clksrc;
        logic dsp_en;
    } bank_state_t;

    localparam bank_state_t BANK_RST = '{
        ready: 1'b0,
        slverr: 1'b0,
        rdata: 32'h0000_0000,
        osr: RST_OSR,
        hi_pend: RST_CNT_HI,
        hi_live: RST_CNT_HI,
        hi_waiting: 1'b0,
        lo: RST_CNT_LO,
        rec_dsp_decimation: RST_REC_DSP_DECIMATION,
        clksrc: RST_CLKSRC,
        dsp_en: 1'b0
    };

    bank_state_t q;
    bank_state_t d;

    logic setup;
    logic access;
    logic mapped;
    logic wr_osr;
    logic wr_hi;
    logic wr_lo;
    logic wr_rec_dsp_decimation;
    logic wr_clksrc;
    logic wr_ctrl;
    logic [31:0] rd_word;

    // One wait-free access phase: ready is raised at the setup edge
    assign setup = PSEL && !PENABLE;
    assign access = PSEL && PENABLE && q.ready;

    assign mapped = reg_hit(PADDR, IDX_OSR) || reg_hit(PADDR, IDX_CNT_HI)
        || reg_hit(PADDR, IDX_CNT_LO) || reg_hit(PADDR, IDX_REC_DSP_DECIMATION)
        || reg_hit(PADDR, IDX_RSVD) || reg_hit(PADDR, IDX_CLKSRC)
        || reg_hit(PADDR, IDX_DSP_CTRL);

    assign wr_osr = access && PWRITE && reg_hit(PADDR, IDX_OSR);
    assign wr_hi = access && PWRITE && reg_hit(PADDR, IDX_CNT_HI);
    assign wr_lo = access && PWRITE && reg_hit(PADDR, IDX_CNT_LO);
    assign wr_rec_dsp_decimation = access && PWRITE && reg_hit(PADDR, IDX_REC_DSP_DECIMATION);
    assign wr_clksrc = access && PWRITE && reg_hit(PADDR, IDX_CLKSRC);
    assign wr_ctrl = access && PWRITE && reg_hit(PADDR, IDX_DSP_CTRL);

    // Reserved bits and the reserved word read as zero
    always_comb begin
        rd_word = 32'h0000_0000;
        if (reg_hit(PADDR, IDX_OSR)) begin
            rd_word[OSR_W-1:0] = q.osr;
        end
        if (reg_hit(PADDR, IDX_CNT_HI)) begin
            rd_word[CNT_HI_W-1:0] = q.hi_pend;
        end
        if (reg_hit(PADDR, IDX_CNT_LO)) begin
            rd_word[CNT_LO_W-1:0] = q.lo;
        end
        if (reg_hit(PADDR, IDX_REC_DSP_DECIMATION)) begin
            rd_word[REC_DSP_DECIMATION_W-1:0] = q.rec_dsp_decimation;
        end
        if (reg_hit(PADDR, IDX_CLKSRC)) begin
            rd_word[CLKSRC_W-1:0] = q.clksrc;
        end
        if (reg_hit(PADDR, IDX_DSP_CTRL)) begin
            rd_word[DSP_EN_BIT] = q.dsp_en;
            rd_word[HI_PEND_BIT] = q.hi_waiting;
        end
    end

    always_comb begin
        d = q;
        d.ready = 1'b0;
        d.slverr = 1'b0;
        if (setup) begin
            d.ready = 1'b1;
            d.slverr = !mapped;
            d.rdata = PWRITE ? 32'h0000_0000 : rd_word;
        end
        if (wr_osr) begin
            d.osr = PWDATA[OSR_W-1:0];
        end
        // High half parks until the low half lands
        if (wr_hi) begin
            d.hi_pend = PWDATA[CNT_HI_W-1:0];
            d.hi_waiting = 1'b1;
        end
        if (wr_lo) begin
            d.lo = PWDATA[CNT_LO_W-1:0];
            d.hi_live = q.hi_pend;
            d.hi_waiting = 1'b0;
        end
        // Upper reserved bits of the write are ignored; only bits 3:0 are stored
        if (wr_rec_dsp_decimation) begin
            d.rec_dsp_decimation = PWDATA[REC_DSP_DECIMATION_W-1:0];
        end
        if (wr_clksrc) begin
            d.clksrc = PWDATA[CLKSRC_W-1:0];
        end
        if (wr_ctrl) begin
            d.dsp_en = PWDATA[DSP_EN_BIT];
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            q <= BANK_RST;
        end else begin
            q <= d;
        end
    end

    rec_dsp_decode u_decode (
        .clk(CLK),
        .rst(RST),
        .osr_code(q.osr),
        .cnt_code({q.hi_live, q.lo}),
        .rec_dsp_decimation_code(q.rec_dsp_decimation),
        .clksrc_code(q.clksrc),
        .dsp_en(q.dsp_en),
        .osr_ratio(OSR_RATIO),
        .instr_count(INSTR_COUNT),
        .rec_dsp_decimation_factor(REC_DSP_DECIMATION_FACTOR),
        .dsp_active(DSP_ACTIVE),
        .clksrc(CLKOUT_SRC)
    );

    assign PRDATA = q.rdata;
    assign PREADY = q.ready;
    assign PSLVERR = q.slverr;

    // Checks on the decoded outputs and the bus timing
    a_osr_zero_max: assert property (@(posedge CLK) disable iff (RST)
        wr_osr && PWDATA[OSR_W-1:0] == '0 |=> ##1 OSR_RATIO == OSR_ZERO_VAL)
        else $error("Oversampling code zero did not give 256");

    a_osr_plain_code: assert property (@(posedge CLK) disable iff (RST)
        wr_osr && PWDATA[OSR_W-1:0] != '0
        |=> ##1 OSR_RATIO == {1'b0, $past(PWDATA[OSR_W-1:0], 2)})
        else $error("Oversampling ratio does not follow its code");

    a_cnt_after_reset: assert property (@(posedge CLK) disable iff (RST)
        $past(RST) |-> {q.hi_live, q.lo} == {RST_CNT_HI, RST_CNT_LO} && !q.hi_waiting)
        else $error("Instruction count not 256 after reset");

    a_cnt_hi_held: assert property (@(posedge CLK) disable iff (RST)
        wr_hi |=> ##1 $stable(INSTR_COUNT) && q.hi_waiting)
        else $error("High half applied before the low half");

    a_cnt_lo_applies: assert property (@(posedge CLK) disable iff (RST)
        wr_lo && q.dsp_en && !wr_ctrl |=> ##1
            INSTR_COUNT[CNT_W-1:0] == {$past(q.hi_pend, 2), $past(PWDATA[CNT_LO_W-1:0], 2)}
            && INSTR_COUNT[CNT_W] == (INSTR_COUNT[CNT_W-1:0] == '0))
        else $error("Low half write did not apply the count");

    a_cnt_zero_max: assert property (@(posedge CLK) disable iff (RST)
        q.dsp_en && q.hi_live == '0 && q.lo == '0 |=> INSTR_COUNT == CNT_ZERO_VAL)
        else $error("All-zero count did not give 32768");

    a_rec_dsp_decimation_decode: assert property (@(posedge CLK) disable iff (RST)
        q.dsp_en |=> REC_DSP_DECIMATION_FACTOR == (($past(q.rec_dsp_decimation) == '0) ? REC_DSP_DECIMATION_ZERO_VAL
            : {1'b0, $past(q.rec_dsp_decimation)}) && REC_DSP_DECIMATION_FACTOR != '0)
        else $error("Decimation factor decode wrong");

    a_gated_idle: assert property (@(posedge CLK) disable iff (RST)
        !q.dsp_en [*2] |-> !DSP_ACTIVE && INSTR_COUNT == '0 && REC_DSP_DECIMATION_FACTOR == '0)
        else $error("Core settings applied while core not selected");

    a_clksrc_follow: assert property (@(posedge CLK) disable iff (RST)
        wr_clksrc |=> ##1 CLKOUT_SRC == clkout_divider_input_t'($past(PWDATA[CLKSRC_W-1:0], 2)))
        else $error("Clock-output source does not follow the select");

    a_rsvd_reads_zero: assert property (@(posedge CLK) disable iff (RST)
        setup && !PWRITE && reg_hit(PADDR, IDX_RSVD) |=> PREADY && PRDATA == '0)
        else $error("Reserved register did not read zero");

    a_apb_one_wait: assert property (@(posedge CLK) disable iff (RST)
        setup |=> PREADY && PSLVERR == !$past(mapped))
        else $error("Access phase not answered in one cycle");

    a_ready_pulse: assert property (@(posedge CLK) disable iff (RST)
        PREADY |=> !PREADY)
        else $error("Ready stood longer than one cycle");

    a_pend_flag: assert property (@(posedge CLK) disable iff (RST)
        wr_hi |=> q.hi_waiting && q.hi_live == $past(q.hi_live))
        else $error("High half not held pending");

    c_hi_then_lo: cover property (@(posedge CLK) disable iff (RST)
        wr_hi ##[2:8] wr_lo);

    c_count_zero: cover property (@(posedge CLK) disable iff (RST)
        INSTR_COUNT == CNT_ZERO_VAL);

    c_unmapped: cover property (@(posedge CLK) disable iff (RST)
        PREADY && PSLVERR);

    c_record_mod_src: cover property (@(posedge CLK) disable iff (RST)
        CLKOUT_SRC == CLKIN_RECORD_MOD);

endmodule : adc_osr_clkmux_regs

// ---- include/osr_regs_pkg.sv ----
// Register indexes, reset values and decode constants of the record-path
// oversampling and clock-mux register bank.
// Assumes a 32-bit APB slave where each 8-bit register takes one aligned word.
package osr_regs_pkg;

    // APB address width
    localparam int APB_AW = 12;

    // Register indexes; byte address is four times the index
    localparam logic [7:0] IDX_OSR = 8'h14;
    localparam logic [7:0] IDX_CNT_HI = 8'h15;
    localparam logic [7:0] IDX_CNT_LO = 8'h16;
    localparam logic [7:0] IDX_REC_DSP_DECIMATION = 8'h17;
    localparam logic [7:0] IDX_RSVD = 8'h18;
    localparam logic [7:0] IDX_CLKSRC = 8'h19;
    localparam logic [7:0] IDX_DSP_CTRL = 8'h3D;

    // Field widths
    localparam int OSR_W = 8;
    localparam int CNT_HI_W = 7;
    localparam int CNT_LO_W = 8;
    localparam int CNT_W = 15;
    localparam int REC_DSP_DECIMATION_W = 4;
    localparam int CLKSRC_W = 3;

    // Reset values
    localparam logic [OSR_W-1:0] RST_OSR = 8'h80;
    localparam logic [CNT_HI_W-1:0] RST_CNT_HI = 7'h01;
    localparam logic [CNT_LO_W-1:0] RST_CNT_LO = 8'h00;
    localparam logic [REC_DSP_DECIMATION_W-1:0] RST_REC_DSP_DECIMATION = 4'h4;
    localparam logic [CLKSRC_W-1:0] RST_CLKSRC = 3'h0;

    // Control register bit positions
    localparam int DSP_EN_BIT = 0;
    localparam int HI_PEND_BIT = 1;

    // Value that an all-zero code stands for
    localparam logic [OSR_W:0] OSR_ZERO_VAL = 9'h100;
    localparam logic [CNT_W:0] CNT_ZERO_VAL = 16'h8000;
    localparam logic [REC_DSP_DECIMATION_W:0] REC_DSP_DECIMATION_ZERO_VAL = 5'h10;

    // Clock-output divider input sources
    typedef enum logic [CLKSRC_W-1:0] {
        CLKIN_MASTER = 3'b000,
        CLKIN_BIT_CLOCK = 3'b001,
        CLKIN_DATA_IN = 3'b010,
        CLKIN_PLL = 3'b011,
        CLKIN_DAC_CLOCK = 3'b100,
        CLKIN_PLAYBACK_MOD = 3'b101,
        CLKIN_ADC_CLOCK = 3'b110,
        CLKIN_RECORD_MOD = 3'b111
    } clkout_divider_input_t;

    function automatic logic reg_hit(input logic [APB_AW-1:0] addr, input logic [7:0] idx);
        return addr == {{(APB_AW-10){1'b0}}, idx, 2'b00};
    endfunction : reg_hit

endpackage : osr_regs_pkg

// ---- hw/rec_dsp_decode.sv ----
// Turns raw register codes into the effective ratio, count and factor values.
// Assumes codes come from registers in the same clock domain.
`timescale 1ns/10ps
module rec_dsp_decode (
    input wire logic clk,
    input wire logic rst,
    input wire logic [osr_regs_pkg::OSR_W-1:0] osr_code,
    input wire logic [osr_regs_pkg::CNT_W-1:0] cnt_code,
    input wire logic [osr_regs_pkg::REC_DSP_DECIMATION_W-1:0] rec_dsp_decimation_code,
    input wire logic [osr_regs_pkg::CLKSRC_W-1:0] clksrc_code,
    input wire logic dsp_en,
    output logic [osr_regs_pkg::OSR_W:0] osr_ratio,
    output logic [osr_regs_pkg::CNT_W:0] instr_count,
    output logic [osr_regs_pkg::REC_DSP_DECIMATION_W:0] rec_dsp_decimation_factor,
    output logic dsp_active,
    output osr_regs_pkg::clkout_divider_input_t clksrc
);
    import osr_regs_pkg::*;

    typedef struct packed {
        logic [OSR_W:0] osr;
        logic [CNT_W:0] cnt;
        logic [REC_DSP_DECIMATION_W:0] rec_dsp_decimation;
        logic active;
        clkout_divider_input_t src;
    } dec_state_t;

    dec_state_t q;
    dec_state_t d;

    always_comb begin
        d = q;
        // Zero code is the top of the range
        d.osr = (osr_code == '0) ? OSR_ZERO_VAL : {1'b0, osr_code};
        d.src = clkout_divider_input_t'(clksrc_code);
        d.active = dsp_en;
        // Gated off so the core never runs on stale settings
        if (dsp_en) begin
            d.cnt = (cnt_code == '0) ? CNT_ZERO_VAL : {1'b0, cnt_code};
            d.rec_dsp_decimation = (rec_dsp_decimation_code == '0) ? REC_DSP_DECIMATION_ZERO_VAL : {1'b0, rec_dsp_decimation_code};
        end else begin
            d.cnt = '0;
            d.rec_dsp_decimation = '0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= '{osr: {1'b0, RST_OSR}, cnt: '0, rec_dsp_decimation: '0, active: 1'b0,
                   src: CLKIN_MASTER};
        end else begin
            q <= d;
        end
    end

    assign osr_ratio = q.osr;
    assign instr_count = q.cnt;
    assign rec_dsp_decimation_factor = q.rec_dsp_decimation;
    assign dsp_active = q.active;
    assign clksrc = q.src;

endmodule : rec_dsp_decode

// ---- testbench/tb_adc_oversampling_clock_mux_regs.sv ----
// Self-checking bench for the oversampling and clock-mux register bank.
// Assumes the package and the bank's top module are compiled first.
`timescale 1ns/10ps
module tb_adc_oversampling_clock_mux_regs;
    import osr_regs_pkg::*;

    typedef struct {
        logic [7:0] idx;
        logic [31:0] wd;
        logic [31:0] rd;
        logic [15:0] out;
    } row_t;

    logic clk, rst, psel, penable, pwrite, pready, pslverr, dsp_active;
    logic [APB_AW-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [8:0] osr_ratio;
    logic [15:0] instr_count;
    logic [4:0] rec_dsp_decimation_factor;
    logic err;
    clkout_divider_input_t clkout_src;
    int failures = 0;
    int n_tests = 0;
    // Ratio and factor kept multiples of each other; reserved bits written zero
    row_t rows [8] = '{
        '{IDX_OSR, 32'h00, 32'h00, 16'h0100}, '{IDX_OSR, 32'h20, 32'h20, 16'h0020},
        '{IDX_OSR, 32'hF0, 32'hF0, 16'h00F0}, '{IDX_OSR, 32'h80, 32'h80, 16'h0080},
        '{IDX_REC_DSP_DECIMATION, 32'h00, 32'h00, 16'h0010}, '{IDX_REC_DSP_DECIMATION, 32'h08, 32'h08, 16'h0008},
        '{IDX_REC_DSP_DECIMATION, 32'h04, 32'h04, 16'h0004}, '{IDX_RSVD, 32'h00, 32'h00, 16'h0000}};

    adc_osr_clkmux_regs dut_u (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .OSR_RATIO(osr_ratio), .INSTR_COUNT(instr_count),
        .REC_DSP_DECIMATION_FACTOR(rec_dsp_decimation_factor), .DSP_ACTIVE(dsp_active), .CLKOUT_SRC(clkout_src));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : summarize

    task automatic chk_rd(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_rd

    task automatic chk_out(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_out

    // Idle edge first, so psel is never assigned twice in one time step
    task automatic apb(input logic wr, input logic [APB_AW-1:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        // Only the watchdog ends a wait that never sees ready
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
        apb(1'b1, {2'b00, idx, 2'b00}, wd);
        chk_out("pslverr", 16'h0, {15'h0, err});
    endtask : wr

    task automatic rdreg(input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, {2'b00, idx, 2'b00}, 32'h0);
        chk_rd("read data", exp, rd);
    endtask : rdreg

    // Decoded outputs land one edge after the access edge
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask : settle

    task automatic do_row(input row_t r);
        wr(r.idx, r.wd);
        settle();
        rdreg(r.idx, r.rd);
        case (r.idx)
            IDX_OSR: chk_out("oversampling ratio", r.out, {7'h0, osr_ratio});
            IDX_REC_DSP_DECIMATION: chk_out("decimation", r.out, {11'h0, rec_dsp_decimation_factor});
            IDX_CLKSRC: chk_out("clock source", r.out, {13'h0, clkout_src});
            default: chk_out("reserved read", r.out, rd[15:0]);
        endcase
    endtask : do_row

    task automatic check_reset(input string name);
        logic [7:0] ix [6] = '{IDX_OSR, IDX_CNT_HI, IDX_CNT_LO, IDX_REC_DSP_DECIMATION, IDX_RSVD, IDX_CLKSRC};
        logic [31:0] ex [6] = '{32'h80, 32'h01, 32'h00, 32'h04, 32'h00, 32'h00};
        for (int i = 0; i < 6; i++) rdreg(ix[i], ex[i]);
        chk_out("oversampling ratio", 16'h0080, {7'h0, osr_ratio});
        chk_out("count while off", 16'h0000, instr_count);
        chk_out("core active", 16'h0000, {10'h0, rec_dsp_decimation_factor, dsp_active});
        chk_out("clock source", 16'h0000, {13'h0, clkout_src});
        $display("test %s done", name);
    endtask : check_reset

    initial begin
        #200000;
        failures++;
        summarize();
    end

    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        check_reset("reset");
        wr(IDX_DSP_CTRL, 32'h1);
        settle();
        chk_out("count on enable", 16'h0100, instr_count);
        chk_out("rec_dsp_decimation on enable", 16'h0009, {10'h0, rec_dsp_decimation_factor, dsp_active});
        for (int i = 0; i < 8; i++) do_row(rows[i]);
        for (int i = 0; i < 8; i++) do_row('{IDX_CLKSRC, 32'(i), 32'(i), 16'(i)});
        $display("test table done");
        // Pending high half must not move the live count; low half is the next command
        wr(IDX_CNT_HI, 32'h7F);
        settle();
        chk_out("count pending", 16'h0100, instr_count);
        wr(IDX_CNT_LO, 32'hFC);
        settle();
        chk_out("count applied", 16'h7FFC, instr_count);
        rdreg(IDX_CNT_HI, 32'h7F);
        rdreg(IDX_DSP_CTRL, 32'h1);
        wr(IDX_CNT_HI, 32'h00);
        wr(IDX_CNT_LO, 32'h00);
        settle();
        chk_out("count zero code", 16'h8000, instr_count);
        $display("test pairing done");
        apb(1'b0, 12'h068, 32'h0);
        chk_out("unmapped error", 16'h1, {15'h0, err});
        chk_rd("unmapped data", 32'h0, rd);
        apb(1'b1, 12'h051, 32'h11);
        chk_out("misaligned error", 16'h1, {15'h0, err});
        settle();
        chk_out("ratio kept", 16'h0080, {7'h0, osr_ratio});
        $display("test errors done");
        wr(IDX_DSP_CTRL, 32'h0);
        settle();
        chk_out("count off", 16'h0000, instr_count);
        chk_out("rec_dsp_decimation off", 16'h0000, {10'h0, rec_dsp_decimation_factor, dsp_active});
        $display("test disable done");
        wr(IDX_OSR, 32'h10);
        settle();
        chk_out("ratio before reset", 16'h0010, {7'h0, osr_ratio});
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        check_reset("mid-run reset");
        summarize();
    end
endmodule : tb_adc_oversampling_clock_mux_regs
